// File: rtl/core_mem_pkg.sv
// Shared constants and types for the core memory organisation and central registers.
// Assumes a single processor clock domain and a synchronous active-high reset.
package core_mem_pkg;

  // Address space sizes.
  localparam int          CODE_SPACE_BYTES    = 65536;
  localparam int          DATA_SPACE_BYTES    = 65536;
  localparam int          INTERNAL_RAM_BYTES          = 256;
  localparam int          SFR_SPACE_BYTES     = 128;
  localparam logic [16:0] FLASH_DEFAULT_BYTES = 17'h0_4000;
  localparam logic [16:0] SRAM_DEFAULT_BYTES  = 17'h0_0400;

  // Internal RAM landmarks.
  localparam logic [7:0] WORK_REG_LAST       = 8'h1f;
  localparam logic [7:0] BIT_AREA_BASE       = 8'h20;
  localparam logic [7:0] BIT_AREA_LAST       = 8'h2f;
  localparam logic [7:0] SFR_BASE            = 8'h80;
  localparam logic [2:0] SFR_BIT_GROUP_LSBS  = 3'h0;

  // Special function register offsets.
  localparam logic [7:0] ADDR_STACK_TOP      = 8'h81;
  localparam logic [7:0] ADDR_DP_LOW         = 8'h82;
  localparam logic [7:0] ADDR_DP_HIGH        = 8'h83;
  localparam logic [7:0] ADDR_DP1_LOW        = 8'h84;
  localparam logic [7:0] ADDR_DP1_HIGH       = 8'h85;
  localparam logic [7:0] ADDR_PTR_SELECT     = 8'h92;
  localparam logic [7:0] ADDR_PAGE           = 8'hc9;
  localparam logic [7:0] ADDR_PSW            = 8'hd0;
  localparam logic [7:0] ADDR_ACC            = 8'he0;
  localparam logic [7:0] ADDR_AUX            = 8'hf0;

  // Reset values.
  localparam logic [7:0]  RESET_BYTE         = 8'h00;
  localparam logic [7:0]  RESET_STACK_TOP    = 8'h07;
  localparam logic [15:0] RESET_POINTER      = 16'h0000;
  localparam logic [7:0]  RESET_PAGE         = 8'h00;

  // Status word fields.
  localparam int PSW_CARRY      = 7;
  localparam int PSW_HALF_CARRY = 6;
  localparam int PSW_USER_ZERO  = 5;
  localparam int PSW_BANK_HI    = 4;
  localparam int PSW_BANK_LO    = 3;
  localparam int PSW_WRAP       = 2;
  localparam int PSW_USER_ONE   = 1;
  localparam int PSW_PARITY     = 0;
  localparam int PTR_SELECT_BIT = 0;

  // Software-writable status bits; parity is excluded.
  localparam logic [7:0] PSW_SW_MASK = 8'hfe;
  localparam logic [7:0] PTR_SELECT_MASK = 8'h01;
  localparam logic [7:0] STACK_STEP = 8'h01;
  localparam logic [15:0] POINTER_STEP = 16'h0001;

  typedef enum logic [2:0] {
    ACCESS_NONE     = 3'b000,
    ACCESS_DIRECT   = 3'b001,
    ACCESS_INDIRECT = 3'b010,
    ACCESS_WORK_REG = 3'b011,
    ACCESS_BIT      = 3'b100
  } access_mode_type;

endpackage

// File: rtl/core_mem_regs.sv
// Core memory organisation: internal RAM, register banks, bit area and central registers.
// Assumes the instruction sequencer drives one access per cycle on mclk.
//
// Function
// [RL1] Separate 64 KB code and data spaces, 256-byte internal RAM, 128-byte register space.
// [RL2] Default 16 KB program flash and 1 KB data SRAM; sizes may be reconfigured.
// [RL3] Working registers at 0x00-0x1F, bit-addressable bytes at 0x20-0x2F.
// [RL4] Upper internal RAM only indirectly; direct addresses there select registers.
// [RL5] Lowest 32 bytes form four banks of eight working registers.
// [RL6] Status bits 4-3 choose bank base 0x00, 0x08, 0x10 or 0x18.
// [RL7] Sixteen bytes after the banks are bit-addressable via bit addresses 0x00-0x7F.
// [RL8] Paged accesses reach one 256-byte page using R0 or R1 as low byte.
// [RL9] Page register forms the upper byte of the paged address.
// [RL10] Status bit 7 is carry and the Boolean one-bit accumulator.
// [RL11] Status bit 6 is set on carry out of accumulator bit 3.
// [RL12] Status bit 2 is set on signed overflow of the accumulator.
// [RL13] Status bit 0 always shows odd parity of the accumulator.
// [RL14] Software writes never change parity; hardware alone updates it.
// [RL15] Status bits 5 and 1 are free software flags.
// [RL16] Stack pointer increments before push, decrements after pop.
// [RL17] Stack lives in internal RAM and holds call and interrupt return addresses.
// [RL18] Data pointer usable as 16-bit register or two 8-bit halves.
// [RL19] Data pointer addresses external moves, table reads and computed jumps.
// [RL20] Instructions use the data pointer chosen by the pointer-select register.
// [RL21] Accumulator supplies operands to and receives results from most instructions.
// [RL22] Auxiliary register serves multiply and divide and general scratch storage.
// [RL23] Pointer-select bit 0 chooses primary (0) or secondary (1) pointer.
`timescale 1ns/10ps

module core_mem_regs
  import core_mem_pkg::*;
(
  input  wire logic            mclk,
  input  wire logic            rst,
  input  wire access_mode_type access_mode,
  input  wire logic [7:0]      access_addr,
  input  wire logic            access_write,
  input  wire logic [7:0]      access_wdata,
  output logic      [7:0]      access_rdata_reg,
  input  wire logic            alu_acc_write,
  input  wire logic [7:0]      alu_acc_value,
  input  wire logic            alu_aux_write,
  input  wire logic [7:0]      alu_aux_value,
  input  wire logic            alu_flag_write,
  input  wire logic            alu_carry,
  input  wire logic            alu_half_carry,
  input  wire logic            alu_wrap,
  input  wire logic            stack_push,
  input  wire logic            stack_pop,
  input  wire logic [7:0]      stack_wdata,
  output logic      [7:0]      stack_rdata_reg,
  input  wire logic            dp_load,
  input  wire logic [15:0]     dp_load_value,
  input  wire logic            dp_increment,
  input  wire logic            paged_use_r1,
  output logic      [7:0]      primary_operand_reg,
  output logic      [7:0]      aux_operand_reg,
  output logic      [7:0]      program_status_word_reg,
  output logic      [7:0]      stack_top_pointer_reg,
  output logic      [15:0]     data_pointer_pair_reg,
  output logic      [15:0]     paged_address_reg,
  output logic                 paged_in_sram_reg,
  output logic                 pointer_in_flash_reg
);

  logic [7:0]  internal_ram [INTERNAL_RAM_BYTES];
  logic [7:0]  psw_store_reg;
  logic [7:0]  paged_window_high_byte_reg;
  logic [15:0] primary_pointer_reg;
  logic [15:0] secondary_pointer_reg;
  logic        pointer_select_reg;

  logic [7:0]  primary_operand_next;
  logic [7:0]  psw_store_next;
  logic [15:0] primary_pointer_next;
  logic [15:0] secondary_pointer_next;
  logic        pointer_select_next;
  logic [1:0]  bank_select;
  logic [7:0]  eff_addr;
  logic        to_sfr;
  logic [7:0]  cur_byte;
  logic [7:0]  write_byte;
  logic [7:0]  read_value;
  logic        sfr_we;
  logic        internal_ram_we;
  logic [7:0]  push_addr;

  // Reads one byte of the register space; unmapped locations read as zero.
  function automatic logic [7:0] sfr_read(input logic [7:0] a);
    logic [7:0] v;
    v = RESET_BYTE;
    if (a == ADDR_STACK_TOP) begin
      v = stack_top_pointer_reg;
    end else if (a == ADDR_DP_LOW) begin
      v = primary_pointer_reg[7:0];
    end else if (a == ADDR_DP_HIGH) begin
      v = primary_pointer_reg[15:8];
    end else if (a == ADDR_DP1_LOW) begin
      v = secondary_pointer_reg[7:0];
    end else if (a == ADDR_DP1_HIGH) begin
      v = secondary_pointer_reg[15:8];
    end else if (a == ADDR_PTR_SELECT) begin
      v = 8'(pointer_select_reg);
    end else if (a == ADDR_PAGE) begin
      v = paged_window_high_byte_reg;
    end else if (a == ADDR_PSW) begin
      v = program_status_word_reg;
    end else if (a == ADDR_ACC) begin
      v = primary_operand_reg;
    end else if (a == ADDR_AUX) begin
      v = aux_operand_reg;
    end
    return v;
  endfunction

  assign bank_select = psw_store_reg[PSW_BANK_HI:PSW_BANK_LO];
  assign push_addr   = stack_top_pointer_reg + STACK_STEP;

  // Resolves the access mode to one byte in internal RAM or in register space.
  always_comb begin
    eff_addr = access_addr;
    to_sfr   = 1'b0;
    case (access_mode)
      ACCESS_DIRECT: begin
        to_sfr = (access_addr >= SFR_BASE); // RL4
      end
      ACCESS_INDIRECT: begin
        to_sfr = 1'b0; // RL4
      end
      ACCESS_WORK_REG: begin
        eff_addr = 8'({bank_select, access_addr[2:0]}); // RL5 RL6
      end
      ACCESS_BIT: begin
        if (access_addr < SFR_BASE) begin
          eff_addr = BIT_AREA_BASE + 8'(access_addr[6:3]); // RL7
        end else begin
          eff_addr = {access_addr[7:3], SFR_BIT_GROUP_LSBS};
          to_sfr   = 1'b1;
        end
      end
      default: begin
        to_sfr = 1'b0;
      end
    endcase
  end

  // Builds the read value and the byte to store, merging single-bit writes.
  always_comb begin
    cur_byte   = to_sfr ? sfr_read(eff_addr) : internal_ram[eff_addr];
    write_byte = access_wdata;
    read_value = cur_byte;
    if (access_mode == ACCESS_BIT) begin
      write_byte                   = cur_byte;
      write_byte[access_addr[2:0]] = access_wdata[0]; // RL7 RL10
      read_value                   = 8'(cur_byte[access_addr[2:0]]);
    end
    sfr_we  = access_write && to_sfr && (access_mode != ACCESS_NONE);
    internal_ram_we = access_write && !to_sfr && (access_mode != ACCESS_NONE);
  end

  // Accumulator: instruction writes through register space win over the datapath result.
  always_comb begin
    primary_operand_next = primary_operand_reg;
    if (sfr_we && (eff_addr == ADDR_ACC)) begin
      primary_operand_next = write_byte; // RL21
    end else if (alu_acc_write) begin
      primary_operand_next = alu_acc_value; // RL21
    end
  end

  // Status word: software writes first, then hardware flag updates take precedence.
  always_comb begin
    psw_store_next = psw_store_reg;
    if (sfr_we && (eff_addr == ADDR_PSW)) begin
      psw_store_next = write_byte & PSW_SW_MASK; // RL14 RL15
    end
    if (alu_flag_write) begin
      psw_store_next[PSW_CARRY]      = alu_carry; // RL10
      psw_store_next[PSW_HALF_CARRY] = alu_half_carry; // RL11
      psw_store_next[PSW_WRAP]       = alu_wrap; // RL12
    end
  end

  // Data pointers: byte writes to either half, or whole 16-bit load and increment.
  always_comb begin
    primary_pointer_next   = primary_pointer_reg;
    secondary_pointer_next = secondary_pointer_reg;
    pointer_select_next    = pointer_select_reg;
    if (sfr_we) begin
      if (eff_addr == ADDR_DP_LOW) begin
        primary_pointer_next[7:0] = write_byte; // RL18
      end else if (eff_addr == ADDR_DP_HIGH) begin
        primary_pointer_next[15:8] = write_byte; // RL18
      end else if (eff_addr == ADDR_DP1_LOW) begin
        secondary_pointer_next[7:0] = write_byte;
      end else if (eff_addr == ADDR_DP1_HIGH) begin
        secondary_pointer_next[15:8] = write_byte;
      end else if (eff_addr == ADDR_PTR_SELECT) begin
        pointer_select_next = write_byte[PTR_SELECT_BIT]; // RL23
      end
    end
    if (dp_load || dp_increment) begin
      if (pointer_select_reg) begin
        secondary_pointer_next = dp_load ? dp_load_value
                                         : secondary_pointer_reg + POINTER_STEP; // RL20
      end else begin
        primary_pointer_next = dp_load ? dp_load_value
                                       : primary_pointer_reg + POINTER_STEP; // RL18 RL20
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      primary_operand_reg <= RESET_BYTE;
    end else begin
      primary_operand_reg <= primary_operand_next;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      aux_operand_reg <= RESET_BYTE;
    end else if (sfr_we && (eff_addr == ADDR_AUX)) begin
      aux_operand_reg <= write_byte; // RL22
    end else if (alu_aux_write) begin
      aux_operand_reg <= alu_aux_value; // RL22
    end
  end

  // Parity is formed from the accumulator's next value so both change together.
  always_ff @(posedge mclk) begin
    if (rst) begin
      psw_store_reg           <= RESET_BYTE;
      program_status_word_reg <= RESET_BYTE;
    end else begin
      psw_store_reg                        <= psw_store_next;
      program_status_word_reg[7:1]         <= psw_store_next[7:1];
      program_status_word_reg[PSW_PARITY]  <= ^primary_operand_next; // RL13 RL14
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      stack_top_pointer_reg <= RESET_STACK_TOP;
    end else if (sfr_we && (eff_addr == ADDR_STACK_TOP)) begin
      stack_top_pointer_reg <= write_byte;
    end else if (stack_push) begin
      stack_top_pointer_reg <= push_addr; // RL16
    end else if (stack_pop) begin
      stack_top_pointer_reg <= stack_top_pointer_reg - STACK_STEP; // RL16
    end
  end

  // Internal RAM: the stack push owns the write port when both ask.
  always_ff @(posedge mclk) begin
    if (stack_push) begin
      internal_ram[push_addr] <= stack_wdata; // RL16 RL17
    end else if (internal_ram_we) begin
      internal_ram[eff_addr] <= write_byte; // RL1 RL3
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      stack_rdata_reg <= RESET_BYTE;
    end else if (stack_pop && !stack_push) begin
      stack_rdata_reg <= internal_ram[stack_top_pointer_reg]; // RL16 RL17
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      access_rdata_reg <= RESET_BYTE;
    end else if (access_mode != ACCESS_NONE) begin
      access_rdata_reg <= read_value; // RL3
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      primary_pointer_reg   <= RESET_POINTER;
      secondary_pointer_reg <= RESET_POINTER;
      pointer_select_reg    <= 1'b0;
      data_pointer_pair_reg <= RESET_POINTER;
    end else begin
      primary_pointer_reg   <= primary_pointer_next;
      secondary_pointer_reg <= secondary_pointer_next;
      pointer_select_reg    <= pointer_select_next;
      data_pointer_pair_reg <= pointer_select_next ? secondary_pointer_next
                                                   : primary_pointer_next; // RL19 RL20 RL23
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      paged_window_high_byte_reg <= RESET_PAGE;
    end else if (sfr_we && (eff_addr == ADDR_PAGE)) begin
      paged_window_high_byte_reg <= write_byte; // RL9
    end
  end

  // Paged address and default-size checks lag their sources by one cycle.
  always_ff @(posedge mclk) begin
    if (rst) begin
      paged_address_reg    <= RESET_POINTER;
      paged_in_sram_reg    <= 1'b0;
      pointer_in_flash_reg <= 1'b0;
    end else begin
      paged_address_reg <= {paged_window_high_byte_reg,
                            internal_ram[8'({bank_select, 3'(paged_use_r1)})]}; // RL8 RL9
      paged_in_sram_reg <= 17'({paged_window_high_byte_reg, STACK_STEP}) <= SRAM_DEFAULT_BYTES; // RL2
      pointer_in_flash_reg <= 17'(data_pointer_pair_reg) < FLASH_DEFAULT_BYTES; // RL1 RL2
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  parity_tracks_acc_a: assert property ( // RL13
    program_status_word_reg[PSW_PARITY] == ^primary_operand_reg)
    else $error("Parity flag differs from accumulator parity.");

  parity_write_block_a: assert property ( // RL14
    (sfr_we && eff_addr == ADDR_PSW && !alu_acc_write)
      |=> program_status_word_reg[PSW_PARITY] == $past(^primary_operand_reg))
    else $error("Software write changed the parity flag.");

  stack_push_step_a: assert property ( // RL16
    (stack_push && !(sfr_we && eff_addr == ADDR_STACK_TOP))
      |=> stack_top_pointer_reg == $past(stack_top_pointer_reg) + STACK_STEP)
    else $error("Stack pointer did not step up on push.");

  stack_pop_step_a: assert property ( // RL16
    (stack_pop && !stack_push && !(sfr_we && eff_addr == ADDR_STACK_TOP))
      |=> stack_top_pointer_reg == $past(stack_top_pointer_reg) - STACK_STEP)
    else $error("Stack pointer did not step down on pop.");

  stack_round_trip_a: assert property ( // RL17
    (stack_push && !sfr_we) ##1 (stack_pop && !stack_push && !sfr_we)
      |=> stack_rdata_reg == $past(stack_wdata, 2))
    else $error("Popped byte differs from pushed byte.");

  hw_flag_update_a: assert property ( // RL10
    alu_flag_write |=> program_status_word_reg[PSW_CARRY] == $past(alu_carry)
      && program_status_word_reg[PSW_HALF_CARRY] == $past(alu_half_carry)
      && program_status_word_reg[PSW_WRAP] == $past(alu_wrap))
    else $error("Arithmetic flags not captured.");

  user_flags_free_a: assert property ( // RL15
    (sfr_we && eff_addr == ADDR_PSW)
      |=> program_status_word_reg[PSW_USER_ZERO] == $past(write_byte[PSW_USER_ZERO])
      && program_status_word_reg[PSW_USER_ONE] == $past(write_byte[PSW_USER_ONE]))
    else $error("User flag write lost.");

  bank_map_write_a: assert property ( // RL6
    (access_mode == ACCESS_WORK_REG && access_write && !stack_push)
      |=> internal_ram[$past(8'({bank_select, access_addr[2:0]}))] == $past(access_wdata))
    else $error("Working register write landed outside the selected bank.");

  upper_direct_sfr_a: assert property ( // RL4
    (access_mode == ACCESS_DIRECT && access_write && access_addr >= SFR_BASE && !stack_push)
      |=> internal_ram[$past(access_addr)] == $past(internal_ram[access_addr]))
    else $error("Direct write reached upper internal RAM.");

  pointer_select_a: assert property ( // RL23
    data_pointer_pair_reg == (pointer_select_reg ? secondary_pointer_reg
                                                 : primary_pointer_reg))
    else $error("Active data pointer does not follow the select bit.");

  paged_high_byte_a: assert property ( // RL9
    ##1 paged_address_reg[15:8] == $past(paged_window_high_byte_reg))
    else $error("Paged address high byte differs from page register.");

  push_then_pop_c: cover property (stack_push ##1 stack_pop);
  bit_area_write_c: cover property (access_mode == ACCESS_BIT && access_write
                                    && access_addr < SFR_BASE);
  bank_switch_c: cover property (sfr_we && eff_addr == ADDR_PSW ##1
                                 access_mode == ACCESS_WORK_REG);
  pointer_swap_c: cover property ($rose(pointer_select_reg) ##1 dp_increment);

endmodule

// File: bench/core_mem_regs_tb.sv
// Self-checking bench for the core memory organisation and central registers.
// Drives every port of the block directly from one clock domain; no partner model.
`timescale 1ns/10ps

module core_mem_regs_tb
  import core_mem_pkg::*;
;
  logic            mclk, rst;
  access_mode_type access_mode;
  logic [7:0]      access_addr, access_wdata, access_rdata_reg;
  logic            access_write, alu_acc_write, alu_aux_write, alu_flag_write;
  logic [7:0]      alu_acc_value, alu_aux_value, stack_wdata, stack_rdata_reg;
  logic            alu_carry, alu_half_carry, alu_wrap, stack_push, stack_pop;
  logic            dp_load, dp_increment, paged_use_r1, paged_in_sram_reg;
  logic [15:0]     dp_load_value, data_pointer_pair_reg, paged_address_reg;
  logic [7:0]      primary_operand_reg, aux_operand_reg, program_status_word_reg;
  logic [7:0]      stack_top_pointer_reg;
  logic            pointer_in_flash_reg;
  int              n_mismatch, total_checks;
  logic [7:0]      pv [6] = '{8'h00, 8'h01, 8'h03, 8'h80, 8'hff, 8'h7f};
  logic [7:0]      bit_a [3] = '{8'h00, 8'h0b, 8'h7f};
  logic [7:0]      byte_a [3] = '{8'h20, 8'h21, 8'h2f};
  logic [7:0]      byte_v [3] = '{8'h01, 8'h08, 8'h80};

  core_mem_regs core_mem_regs_inst (
    .mclk(mclk), .rst(rst), .access_mode(access_mode), .access_addr(access_addr),
    .access_write(access_write), .access_wdata(access_wdata),
    .access_rdata_reg(access_rdata_reg), .alu_acc_write(alu_acc_write),
    .alu_acc_value(alu_acc_value), .alu_aux_write(alu_aux_write),
    .alu_aux_value(alu_aux_value), .alu_flag_write(alu_flag_write), .alu_carry(alu_carry),
    .alu_half_carry(alu_half_carry), .alu_wrap(alu_wrap), .stack_push(stack_push),
    .stack_pop(stack_pop), .stack_wdata(stack_wdata), .stack_rdata_reg(stack_rdata_reg),
    .dp_load(dp_load), .dp_load_value(dp_load_value), .dp_increment(dp_increment),
    .paged_use_r1(paged_use_r1), .primary_operand_reg(primary_operand_reg),
    .aux_operand_reg(aux_operand_reg), .program_status_word_reg(program_status_word_reg),
    .stack_top_pointer_reg(stack_top_pointer_reg),
    .data_pointer_pair_reg(data_pointer_pair_reg), .paged_address_reg(paged_address_reg),
    .paged_in_sram_reg(paged_in_sram_reg), .pointer_in_flash_reg(pointer_in_flash_reg)
  );

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // One access driven at the next edge and taken at the one after; results are settled on return.
  task automatic acc_op(input access_mode_type m, input logic [7:0] a, input logic w,
                        input logic [7:0] d);
    @(posedge mclk);
    access_mode  <= m;
    access_addr  <= a;
    access_write <= w;
    access_wdata <= d;
    @(posedge mclk);
    access_mode  <= ACCESS_NONE;
    access_write <= 1'b0;
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    acc_op(ACCESS_DIRECT, a, 1'b1, d);
  endtask

  task automatic rd(input access_mode_type m, input logic [7:0] a, input logic [7:0] exp);
    acc_op(m, a, 1'b0, 8'h00);
    check(access_rdata_reg, exp);
  endtask

  // Lets the strobes set at the last edge be taken, then drops them all.
  task automatic settle();
    @(posedge mclk);
    alu_acc_write  <= 1'b0;
    alu_aux_write  <= 1'b0;
    alu_flag_write <= 1'b0;
    stack_push     <= 1'b0;
    stack_pop      <= 1'b0;
    dp_load        <= 1'b0;
    dp_increment   <= 1'b0;
    #1;
  endtask

  initial begin
    repeat (5000) @(posedge mclk);
    n_mismatch++;
    wrap_up();
  end

  initial begin
    {rst, access_write, alu_acc_write, alu_aux_write, alu_flag_write} = 5'b10000;
    {alu_carry, alu_half_carry, alu_wrap, stack_push, stack_pop} = 5'b00000;
    {dp_load, dp_increment, paged_use_r1} = 3'b000;
    access_mode = ACCESS_NONE;
    {access_addr, access_wdata, alu_acc_value, alu_aux_value, stack_wdata} = '0;
    dp_load_value = 16'h0000;
    n_mismatch = 0;
    total_checks = 0;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    #1;
    check({primary_operand_reg, aux_operand_reg}, 16'h0000);
    check({program_status_word_reg, stack_top_pointer_reg}, 16'h0007);
    check(data_pointer_pair_reg, 16'h0000);
    rd(ACCESS_DIRECT, ADDR_PAGE, 8'h00);
    foreach (pv[i]) begin
      wr(ADDR_ACC, pv[i]);
      check(program_status_word_reg, {7'h00, ^pv[i]});
    end
    wr(ADDR_PSW, 8'h00);
    check(program_status_word_reg, 16'h0001);
    wr(ADDR_PSW, 8'h22);
    rd(ACCESS_DIRECT, ADDR_PSW, 8'h23);
    wr(ADDR_PSW, 8'h00);
    @(posedge mclk);
    {alu_acc_write, alu_flag_write, alu_carry, alu_half_carry, alu_wrap} <= 5'b11101;
    alu_acc_value <= 8'h07;
    settle();
    check({primary_operand_reg, program_status_word_reg}, 16'h0785);
    @(posedge mclk);
    {alu_aux_write, alu_flag_write, alu_carry, alu_half_carry, alu_wrap} <= 5'b11010;
    alu_aux_value <= 8'h5a;
    settle();
    check({aux_operand_reg, program_status_word_reg}, 16'h5a41);
    rd(ACCESS_DIRECT, ADDR_AUX, 8'h5a);
    wr(ADDR_PSW, 8'h00);
    acc_op(ACCESS_INDIRECT, 8'he0, 1'b1, 8'h77);
    check(primary_operand_reg, 8'h07);
    rd(ACCESS_INDIRECT, 8'he0, 8'h77);
    rd(ACCESS_DIRECT, 8'he0, 8'h07);
    acc_op(ACCESS_INDIRECT, 8'h86, 1'b1, 8'ha5);
    wr(8'h86, 8'h5a);
    rd(ACCESS_DIRECT, 8'h86, 8'h00);
    rd(ACCESS_INDIRECT, 8'h86, 8'ha5);
    for (int b = 0; b < 4; b++) begin
      wr(ADDR_PSW, 8'(b << 3));
      acc_op(ACCESS_WORK_REG, 8'h03, 1'b1, 8'h40 + 8'(b));
    end
    wr(ADDR_PSW, 8'h00);
    for (int b = 0; b < 4; b++) begin
      rd(ACCESS_INDIRECT, 8'(b * 8 + 3), 8'h40 + 8'(b));
    end
    rd(ACCESS_WORK_REG, 8'h03, 8'h40);
    foreach (bit_a[i]) begin
      wr(byte_a[i], 8'h00);
      acc_op(ACCESS_BIT, bit_a[i], 1'b1, 8'h01);
      rd(ACCESS_DIRECT, byte_a[i], byte_v[i]);
      rd(ACCESS_BIT, bit_a[i], 8'h01);
    end
    rd(ACCESS_BIT, 8'h0c, 8'h00);
    @(posedge mclk);
    stack_push  <= 1'b1;
    stack_wdata <= 8'haa;
    settle();
    check(stack_top_pointer_reg, 8'h08);
    rd(ACCESS_INDIRECT, 8'h08, 8'haa);
    @(posedge mclk);
    stack_push  <= 1'b1;
    stack_wdata <= 8'hbb;
    @(posedge mclk);
    stack_push <= 1'b0;
    stack_pop  <= 1'b1;
    #1;
    check(stack_top_pointer_reg, 8'h09);
    settle();
    check({stack_rdata_reg, stack_top_pointer_reg}, 16'hbb08);
    @(posedge mclk);
    stack_pop <= 1'b1;
    settle();
    check({stack_rdata_reg, stack_top_pointer_reg}, 16'haa07);
    wr(ADDR_PAGE, 8'h80);
    wr(8'h00, 8'h34);
    wr(8'h01, 8'h56);
    @(posedge mclk);
    #1;
    check({15'h0000, paged_in_sram_reg}, 16'h0000);
    check(paged_address_reg, 16'h8034);
    @(posedge mclk);
    paged_use_r1 <= 1'b1;
    wr(ADDR_PAGE, 8'h03);
    @(posedge mclk);
    #1;
    check(paged_address_reg, 16'h0356);
    check({15'h0000, paged_in_sram_reg}, 16'h0001);
    @(posedge mclk);
    dp_load       <= 1'b1;
    dp_load_value <= 16'h1234;
    settle();
    @(posedge mclk);
    dp_increment <= 1'b1;
    settle();
    check(data_pointer_pair_reg, 16'h1235);
    rd(ACCESS_DIRECT, ADDR_DP_LOW, 8'h35);
    rd(ACCESS_DIRECT, ADDR_DP_HIGH, 8'h12);
    wr(ADDR_DP_HIGH, 8'h3f);
    wr(ADDR_DP_LOW, 8'hff);
    @(posedge mclk);
    #1;
    check({15'h0000, pointer_in_flash_reg}, 16'h0001);
    @(posedge mclk);
    dp_increment <= 1'b1;
    settle();
    check(data_pointer_pair_reg, 16'h4000);
    @(posedge mclk);
    #1;
    check({15'h0000, pointer_in_flash_reg}, 16'h0000);
    wr(ADDR_PTR_SELECT, 8'hff);
    rd(ACCESS_DIRECT, ADDR_PTR_SELECT, 8'h01);
    @(posedge mclk);
    dp_load       <= 1'b1;
    dp_load_value <= 16'hbeef;
    settle();
    check(data_pointer_pair_reg, 16'hbeef);
    rd(ACCESS_DIRECT, ADDR_DP1_LOW, 8'hef);
    wr(ADDR_PTR_SELECT, 8'h00);
    check(data_pointer_pair_reg, 16'h4000);
    wrap_up();
  end
endmodule
